// File: rtl/avsmf_regs.svh
// Purpose: field encodings and sizes for the signaling message framer
// Assumes: included by the package and the framer
// Notes:   all constants live here, the package holds the types
`ifndef AVSMF_REGS_SVH
`define AVSMF_REGS_SVH
`define AVSMF_PT_SINGLE    2'h0
`define AVSMF_PT_START     2'h1
`define AVSMF_PT_CONT      2'h2
`define AVSMF_PT_END       2'h3
`define AVSMF_MT_CMD       2'h0
`define AVSMF_MT_RFD       2'h1
`define AVSMF_MT_ACC       2'h2
`define AVSMF_MT_REJ       2'h3
`define AVSMF_SIG_DISCOVER 6'h01
`define AVSMF_SIG_ABORT    6'h0A
`define AVSMF_SIG_SECURITY 6'h0B
`define AVSMF_SIG_RSV      2'h0
`define AVSMF_HL_SINGLE    8'h02
`define AVSMF_HL_START     8'h03
`define AVSMF_HL_FRAG      8'h01
`define AVSMF_MTU          48
`define AVSMF_BUF          64
`endif

// File: rtl/avsmf_pkg.sv
// Purpose: types of the signaling message framer
// Assumes: avsmf_regs.svh gives encodings and buffer depth
// Notes:   whole framer state is one packed struct
`include "avsmf_regs.svh"
package avsmf_pkg;
    typedef struct packed {
        logic [3:0] label;
        logic [1:0] ptype;
        logic [1:0] mtype;
    } avsmf_hdr_t;
    typedef struct packed {
        logic [3:0] label;
        logic [1:0] mtype;
        logic [5:0] sig;
        logic [7:0] len;
    } avsmf_msg_t;
    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_CALC = 3'b010,
        TX_SEND = 3'b100
    } avsmf_tx_t;
    typedef struct packed {
        avsmf_tx_t                       tx;
        avsmf_msg_t                      tm;
        logic [7:0]                      rem;
        logic [7:0]                      nosp;
        logic [7:0]                      pnum;
        logic [7:0]                      pcnt;
        logic [7:0]                      bidx;
        logic [1:0]                      ptype;
        logic                            abrt;
        logic [3:0]                      abrt_lbl;
        logic                            ov;
        logic                            osop;
        logic [7:0]                      od;
        logic                            ol;
        logic [7:0]                      olen;
        logic [15:0]                     outst;
        logic [3:0]                      cmd_lbl;
        logic [5:0]                      cmd_sig;
        logic [`AVSMF_BUF-1:0][7:0]      tbuf;
        logic [`AVSMF_BUF-1:0][7:0]      rbuf;
        logic                            in_msg;
        logic                            bad;
        avsmf_msg_t                      rm;
        logic [1:0]                      rpt;
        logic [7:0]                      rpos;
        logic [7:0]                      rnosp;
        logic [7:0]                      rgot;
        logic [7:0]                      slen;
        logic                            rv;
        logic [7:0]                      rd;
    } avsmf_st_t;
endpackage : avsmf_pkg

// File: rtl/avsmf_framer.sv
// Purpose: peer side framer and deframer of signaling messages
// Assumes: packet layer on the same clock, one byte per beat, last marks packet end
// Notes:   message bodies are held in flip-flop buffers of AVSMF_BUF bytes
`timescale 1ns/10ps
`default_nettype none
`include "avsmf_regs.svh"

// What this block does
// RULE1 - one message per packet; last marks each packet's end
// RULE2 - all fragments of a message leave before the next message
// RULE3 - abort may cut a sequence; unsent fragments are dropped
// RULE4 - header octet: label, packet type, message type from msb down
// RULE5 - response carries label of the received command
// RULE6 - packet type bits 3..2: single, start, continue, end
// RULE7 - message type bits 1..0: command, reserved, accept, reject
// RULE8 - start header: common octet, fragment count, signal octet
// RULE9 - single header: common octet then signal octet
// RULE10 - continue and end carry only the common octet
// RULE11 - response carries signal identifier of the received command
// RULE12 - messages above the transfer unit are fragmented
// RULE13 - start and continue packets have identical length
// RULE14 - end packet no longer than start packet
// RULE15 - reassembly sized from start length times fragment count; code uses a fixed AVSMF_BUF byte buffer instead
// RULE16 - corrupted messages dropped silently, no reply
// RULE17 - response with unknown label is dropped
// RULE18 - reserved message type is dropped
// RULE19 - out of order packet types are dropped
// RULE20 - fragment count mismatch drops the message
// RULE21 - signal codes 0x01 discovery to 0x0B, abort 0x0A
// RULE22 - signal identifier in six low bits, high bits sent zero
module avsmf_framer #(
    parameter int unsigned MTU = `AVSMF_MTU
) (
    input  wire logic                              clk,
    input  wire logic                              reset,
    input  wire logic                              tx_wr,
    input  wire logic [$clog2(`AVSMF_BUF)-1:0]     tx_wr_idx,
    input  wire logic [7:0]                        tx_wr_data,
    input  wire logic                              tx_go,
    input  wire avsmf_pkg::avsmf_msg_t             tx_msg,
    input  wire logic                              tx_abort,
    input  wire logic [3:0]                        tx_abort_label,
    output logic                                   tx_busy,
    output logic                                   pkt_valid,
    output logic [7:0]                             pkt_data,
    output logic                                   pkt_last,
    input  wire logic                              pkt_ready,
    input  wire logic                              rx_valid,
    input  wire logic [7:0]                        rx_data,
    input  wire logic                              rx_last,
    output logic                                   rx_msg_valid,
    output avsmf_pkg::avsmf_msg_t                  rx_msg,
    input  wire logic [$clog2(`AVSMF_BUF)-1:0]     rx_rd_idx,
    output logic [7:0]                             rx_rd_data
);
    localparam logic [7:0] MTU8 = 8'(MTU);

    avsmf_pkg::avsmf_st_t s_q;
    avsmf_pkg::avsmf_st_t n;
    avsmf_pkg::avsmf_hdr_t h;
    logic [1:0] pt;
    logic [7:0] hl;
    logic [7:0] nb;
    logic [7:0] plen;
    logic       last;
    logic       free;
    logic       ok;

    function automatic logic [7:0] hdr_len(input logic [1:0] p);
        hdr_len = (p == `AVSMF_PT_SINGLE) ? `AVSMF_HL_SINGLE :
                  (p == `AVSMF_PT_START)  ? `AVSMF_HL_START  : `AVSMF_HL_FRAG;
    endfunction : hdr_len

    // -------------------------------------------------------------
    // receive path, then transmit path
    // -------------------------------------------------------------
    always_comb
    begin
        n    = s_q;
        n.rv = 1'b0;
        h    = avsmf_pkg::avsmf_hdr_t'(rx_data);
        pt   = `AVSMF_PT_SINGLE;
        hl   = 8'h00;
        nb   = 8'h00;
        plen = 8'h00;
        last = 1'b0;
        ok   = 1'b0;
        free = !s_q.ov || pkt_ready;
        n.rd = s_q.rbuf[rx_rd_idx];
        if (rx_valid)
        begin
            if (s_q.rpos == 8'h00)
            begin
                n.rpt = h.ptype;
                if (h.ptype == `AVSMF_PT_SINGLE || h.ptype == `AVSMF_PT_START)
                begin
                    // a fresh sequence replaces any partial one
                    n.rm.label = h.label;
                    n.rm.mtype = h.mtype;                                       // RULE7
                    n.rm.len   = 8'h00;
                    n.rgot     = 8'h01;
                    n.bad      = (h.mtype == `AVSMF_MT_RFD) ||                  // RULE18
                                 (h.mtype[1] && !s_q.outst[h.label]);           // RULE17
                end
                else
                begin
                    n.rgot = s_q.rgot + 8'h01;
                    if (!s_q.in_msg || s_q.rgot >= s_q.rnosp)
                        n.bad = 1'b1;                                           // RULE19
                end
            end
            else if (s_q.rpt == `AVSMF_PT_START && s_q.rpos == 8'h01)
                n.rnosp = rx_data;                                              // RULE8
            else if (s_q.rpos < hdr_len(s_q.rpt))
                n.rm.sig = rx_data[5:0];                                        // RULE22
            else if (s_q.rm.len == 8'(`AVSMF_BUF))
                n.bad = 1'b1;                                                   // RULE15
            else
            begin
                n.rbuf[s_q.rm.len[$clog2(`AVSMF_BUF)-1:0]] = rx_data;
                n.rm.len = s_q.rm.len + 8'h01;
            end
            n.rpos = s_q.rpos + 8'h01;
            if (rx_last)
            begin
                n.rpos = 8'h00;
                plen   = s_q.rpos + 8'h01;
                pt     = n.rpt;
                ok     = !n.bad && plen >= hdr_len(pt);                         // RULE10
                case (pt)
                    `AVSMF_PT_START:
                    begin
                        n.slen = plen;
                        ok     = ok && n.rnosp >= 8'h02;
                    end
                    `AVSMF_PT_CONT:
                        ok = ok && plen == s_q.slen;                            // RULE13
                    `AVSMF_PT_END:
                        ok = ok && plen <= s_q.slen && n.rgot == s_q.rnosp;     // RULE20
                    default:
                        ok = ok;
                endcase
                n.in_msg = 1'b0;
                if (ok && (pt == `AVSMF_PT_SINGLE || pt == `AVSMF_PT_END))
                begin
                    n.rv = 1'b1;                                                // RULE16
                    if (n.rm.mtype[1])
                        n.outst[n.rm.label] = 1'b0;
                    else
                    begin
                        n.cmd_lbl = n.rm.label;
                        n.cmd_sig = n.rm.sig;
                    end
                end
                else if (ok)
                    n.in_msg = 1'b1;
            end
        end

        if (free)
            n.ov = 1'b0;
        case (s_q.tx)
            avsmf_pkg::TX_IDLE:
            begin
                n.abrt = 1'b0;
                if (tx_wr)
                    n.tbuf[tx_wr_idx] = tx_wr_data;
                if (tx_go)
                begin
                    n.tm = tx_msg;
                    if (tx_msg.mtype != `AVSMF_MT_CMD)
                    begin
                        n.tm.label = s_q.cmd_lbl;                               // RULE5
                        n.tm.sig   = s_q.cmd_sig;                               // RULE11
                    end
                    n.nosp = 8'h01;
                    n.pnum = 8'h00;
                    n.pcnt = 8'h00;
                    n.bidx = 8'h00;
                    n.tx   = avsmf_pkg::TX_SEND;
                    if ({1'b0, tx_msg.len} + 9'h002 > 9'(MTU))
                    begin
                        n.rem = tx_msg.len - (MTU8 - `AVSMF_HL_START);          // RULE12
                        n.tx  = avsmf_pkg::TX_CALC;
                    end
                end
            end
            avsmf_pkg::TX_CALC:
            begin
                // one fragment per cycle avoids a divider
                n.nosp = s_q.nosp + 8'h01;
                if (s_q.rem <= MTU8 - 8'h01)
                    n.tx = avsmf_pkg::TX_SEND;
                else
                    n.rem = s_q.rem - (MTU8 - 8'h01);
            end
            avsmf_pkg::TX_SEND:
            begin
                if (free)
                begin
                    if (s_q.pcnt == 8'h00 && s_q.abrt)
                    begin
                        n.abrt     = 1'b0;                                      // RULE3
                        n.tm.label = s_q.abrt_lbl;
                        n.tm.mtype = `AVSMF_MT_CMD;
                        n.tm.sig   = `AVSMF_SIG_ABORT;                          // RULE21
                        n.tm.len   = 8'h00;
                        n.nosp     = 8'h01;
                        n.pnum     = 8'h00;
                        n.bidx     = 8'h00;
                    end
                    pt = (n.pnum == 8'h00) ?                                    // RULE6
                         ((n.nosp == 8'h01) ? `AVSMF_PT_SINGLE : `AVSMF_PT_START) :
                         ((n.pnum == n.nosp - 8'h01) ? `AVSMF_PT_END : `AVSMF_PT_CONT);
                    hl = hdr_len(pt);
                    nb = n.bidx;
                    if (n.pcnt == 8'h00)
                    begin
                        n.od = {n.tm.label, pt, n.tm.mtype};                    // RULE4
                        if (n.pnum == 8'h00 && n.tm.mtype == `AVSMF_MT_CMD)
                            n.outst[n.tm.label] = 1'b1;
                    end
                    else if (pt == `AVSMF_PT_START && n.pcnt == 8'h01)
                        n.od = n.nosp;                                          // RULE8
                    else if (n.pcnt < hl)
                        n.od = {`AVSMF_SIG_RSV, n.tm.sig};                      // RULE9
                    else
                    begin
                        n.od   = s_q.tbuf[n.bidx[$clog2(`AVSMF_BUF)-1:0]];
                        nb     = n.bidx + 8'h01;
                        n.bidx = nb;
                    end
                    last = (n.pcnt + 8'h01 == MTU8) ||                          // RULE13
                           (n.pcnt + 8'h01 >= hl && nb == n.tm.len);            // RULE14
                    n.ov    = 1'b1;
                    n.osop  = (n.pcnt == 8'h00);
                    n.ol    = last;                                             // RULE1
                    n.ptype = pt;
                    n.pcnt  = n.pcnt + 8'h01;
                    if (last)
                    begin
                        n.olen = n.pcnt;
                        n.pcnt = 8'h00;
                        n.pnum = n.pnum + 8'h01;
                        if (pt == `AVSMF_PT_SINGLE || pt == `AVSMF_PT_END)
                            n.tx = avsmf_pkg::TX_IDLE;                          // RULE2
                    end
                end
            end
            default:
                n.tx = avsmf_pkg::TX_IDLE;
        endcase
        // a late abort request is kept, not lost to the consume above
        if (tx_abort && s_q.tx != avsmf_pkg::TX_IDLE)
        begin
            n.abrt     = 1'b1;
            n.abrt_lbl = tx_abort_label;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s_q    <= '0;
            s_q.tx <= avsmf_pkg::TX_IDLE;
        end
        else
            s_q <= n;
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    assign tx_busy      = (s_q.tx != avsmf_pkg::TX_IDLE);
    assign pkt_valid    = s_q.ov;
    assign pkt_data     = s_q.od;
    assign pkt_last     = s_q.ol;
    assign rx_msg_valid = s_q.rv;
    assign rx_msg       = s_q.rm;
    assign rx_rd_data   = s_q.rd;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    a_hdr_ptype: assert property (@(posedge clk) disable iff (reset) // RULE6
        pkt_valid && s_q.osop
        |-> pkt_data[3:2] == s_q.ptype && pkt_data[3] == (s_q.pnum != 8'h00))
        else $error("header packet type differs from sequence position");
    a_no_rfd_out: assert property (@(posedge clk) disable iff (reset) // RULE7
        pkt_valid && s_q.osop |-> pkt_data[1:0] != `AVSMF_MT_RFD)
        else $error("reserved message type transmitted");
    a_equal_len: assert property (@(posedge clk) disable iff (reset) // RULE13
        pkt_valid && pkt_last && (s_q.ptype == `AVSMF_PT_START ||
        s_q.ptype == `AVSMF_PT_CONT) |-> s_q.olen == MTU8)
        else $error("start or continue packet not full length");
    a_end_short: assert property (@(posedge clk) disable iff (reset) // RULE14
        pkt_valid && pkt_last && s_q.ptype == `AVSMF_PT_END
        |-> s_q.olen <= MTU8 && s_q.olen >= `AVSMF_HL_FRAG)
        else $error("end packet longer than start packet");
    a_byte_hold: assert property (@(posedge clk) disable iff (reset) // RULE1
        pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_data)
        && $stable(pkt_last))
        else $error("stalled byte changed");
    a_frag_follow: assert property (@(posedge clk) disable iff (reset) // RULE2
        pkt_valid && pkt_last && pkt_ready && (s_q.ptype == `AVSMF_PT_START ||
        s_q.ptype == `AVSMF_PT_CONT) |=> s_q.tx == avsmf_pkg::TX_SEND)
        else $error("message left before its last fragment");
    a_abort_next: assert property (@(posedge clk) disable iff (reset) // RULE3
        s_q.tx == avsmf_pkg::TX_SEND && s_q.pcnt == 8'h00 && s_q.abrt && free
        |=> pkt_data[3:2] == `AVSMF_PT_SINGLE && s_q.tm.sig == `AVSMF_SIG_ABORT)
        else $error("abort did not replace pending fragments");
    a_rx_no_rfd: assert property (@(posedge clk) disable iff (reset) // RULE18
        rx_msg_valid |-> rx_msg.mtype != `AVSMF_MT_RFD)
        else $error("reserved message type delivered");
    a_rx_drop: assert property (@(posedge clk) disable iff (reset) // RULE16
        rx_valid && rx_last && n.bad |=> !rx_msg_valid)
        else $error("corrupted message delivered");
endmodule : avsmf_framer
`default_nettype wire

// File: tb/avsmf_peer.sv
// Purpose: peer signaling entity model on the packet layer
// Assumes: one byte per beat, last flags the final byte of a packet
// Notes:   ready stalls at random so held output bytes get exercised
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// peer model
// ----------------------------------------
module avsmf_peer (
    input  wire logic       clk,
    input  wire logic       pkt_valid,
    input  wire logic [7:0] pkt_data,
    input  wire logic       pkt_last,
    output logic            pkt_ready,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_last
);
    logic [8:0] got[$];
    logic [8:0] rxq[$];
    logic [8:0] b;
    initial
    begin
        pkt_ready = 1'b0;
        rx_valid  = 1'b0;
        rx_data   = 8'h00;
        rx_last   = 1'b0;
    end
    always @(posedge clk)
    begin
        if (pkt_valid === 1'b1 && pkt_ready)
            got.push_back({pkt_last, pkt_data});
        pkt_ready <= ($urandom % 4) != 0;
        if (rxq.size() != 0)
        begin
            b = rxq.pop_front();
            rx_valid <= 1'b1;
            rx_data  <= b[7:0];
            rx_last  <= b[8];
        end
        else
        begin
            rx_valid <= 1'b0;
            rx_last  <= 1'b0;
            rx_data  <= ~rx_data; // idle line must not repeat a stale byte
        end
    end
endmodule : avsmf_peer
`default_nettype wire

// File: tb/testbench.sv
// Purpose: self-checking bench of the signaling message framer
// Assumes: MTU shrunk to 8 so fragmentation shows with short bodies
// Notes:   expected packets come from a byte-queue model in the bench
`timescale 1ns/10ps
`default_nettype none
`define chk(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("mismatch at %0t: got %h exp %h", $time, (a), (b)); end end
// ----------------------------------------
// bench top
// ----------------------------------------
module testbench;
    localparam int MTU = 8;
    logic clk, reset, tx_wr, tx_go, tx_abort, tx_busy, pkt_valid, pkt_last, pkt_ready;
    logic rx_valid, rx_last, rx_msg_valid;
    logic [5:0] tx_wr_idx, rx_rd_idx, csig;
    logic [7:0] tx_wr_data, pkt_data, rx_data, rx_rd_data;
    logic [3:0] tx_abort_label, clbl;
    avsmf_pkg::avsmf_msg_t tx_msg, rx_msg, em;
    logic [7:0] body[64];
    logic [8:0] exp[$];
    int bad_count, num_checks, nval, i;
    avsmf_framer #(.MTU(MTU)) uut (.clk(clk), .reset(reset), .tx_wr(tx_wr),
        .tx_wr_idx(tx_wr_idx), .tx_wr_data(tx_wr_data), .tx_go(tx_go), .tx_msg(tx_msg),
        .tx_abort(tx_abort), .tx_abort_label(tx_abort_label), .tx_busy(tx_busy),
        .pkt_valid(pkt_valid), .pkt_data(pkt_data), .pkt_last(pkt_last),
        .pkt_ready(pkt_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
        .rx_msg_valid(rx_msg_valid), .rx_msg(rx_msg), .rx_rd_idx(rx_rd_idx),
        .rx_rd_data(rx_rd_data));
    avsmf_peer peer (.clk(clk), .pkt_valid(pkt_valid), .pkt_data(pkt_data),
        .pkt_last(pkt_last), .pkt_ready(pkt_ready), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_last(rx_last));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
        if (rx_msg_valid === 1'b1)
            nval++;
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test
    task automatic put(input logic [7:0] b);
        exp.push_back({1'b0, b});
    endtask : put
    task automatic fill(input int n);
        for (int k = 0; k < n; k++)
            body[k] = 8'($urandom);
    endtask : fill
    task automatic build(input logic [3:0] l, input logic [1:0] mt, input logic [5:0] s,
                         input int n);
        exp.delete();
        put({l, (n + 2 <= MTU) ? `AVSMF_PT_SINGLE : `AVSMF_PT_START, mt});
        if (n + 2 > MTU)
            put(8'(1 + (n + 1) / (MTU - 1)));
        put({2'h0, s});
        for (int k = 0; k < n; k++)
        begin
            if (n + 2 > MTU && k >= MTU - 3 && (k - MTU + 3) % (MTU - 1) == 0)
            begin
                exp[exp.size()-1][8] = 1'b1;
                put({l, (n - k <= MTU - 1) ? `AVSMF_PT_END : `AVSMF_PT_CONT, mt});
            end
            put(body[k]);
        end
        exp[exp.size()-1][8] = 1'b1;
    endtask : build
    task automatic send(input logic [3:0] l, input logic [1:0] mt, input logic [5:0] s,
                        input int n, input bit ab);
        int k;
        peer.got.delete();
        for (k = 0; k < n; k++)
        begin
            @(posedge clk);
            tx_wr      <= 1'b1;
            tx_wr_idx  <= 6'(k);
            tx_wr_data <= body[k];
        end
        @(posedge clk);
        tx_wr  <= 1'b0;
        tx_go  <= 1'b1;
        tx_msg <= '{l, mt, s, 8'(n)};
        @(posedge clk);
        tx_go <= 1'b0;
        @(negedge clk);
        `chk(tx_busy, 1'b1)
        if (mt != `AVSMF_MT_CMD)
            build(clbl, mt, csig, n);
        else
            build(l, mt, s, n);
        if (ab)
        begin
            for (k = 0; k < 500 && peer.got.size() == 0; k++)
                @(posedge clk);
            if (k == 500)
            begin
                bad_count++;
                stop_test();
            end
            @(posedge clk);
            tx_abort       <= 1'b1;
            tx_abort_label <= l + 4'h1;
            @(posedge clk);
            tx_abort <= 1'b0;
            exp = exp[0:MTU-1];
            put({l + 4'h1, `AVSMF_PT_SINGLE, `AVSMF_MT_CMD});
            put({2'h0, `AVSMF_SIG_ABORT});
            exp[exp.size()-1][8] = 1'b1;
        end
        for (k = 0; k < 3000 && !(tx_busy === 1'b0 && peer.got.size() >= exp.size()); k++)
            @(posedge clk);
        if (k == 3000)
        begin
            bad_count++;
            stop_test();
        end
        repeat (4) @(posedge clk);
        `chk(peer.got.size(), exp.size())
        for (k = 0; k < exp.size(); k++)
            `chk(peer.got[k], exp[k])
    endtask : send
    task automatic recv(input logic [3:0] l, input logic [1:0] mt, input logic [5:0] s,
                        input int n, input bit good);
        int k;
        int v;
        v = nval;
        @(posedge clk);
        for (k = 0; k < exp.size(); k++)
            peer.rxq.push_back(exp[k]);
        for (k = 0; k < 500 && peer.rxq.size() != 0; k++)
            @(posedge clk);
        if (k == 500)
        begin
            bad_count++;
            stop_test();
        end
        repeat (4) @(posedge clk);
        `chk(nval - v, int'(good))
        if (good)
        begin
            em = '{l, mt, s, 8'(n)};
            `chk(rx_msg, em)
            for (k = 0; k < n; k++)
            begin
                @(posedge clk);
                rx_rd_idx <= 6'(k);
                @(posedge clk);
                @(negedge clk);
                `chk(rx_rd_data, body[k])
            end
            // only a received command sets what a response echoes
            if (mt == `AVSMF_MT_CMD)
            begin
                clbl = l;
                csig = s;
            end
        end
    endtask : recv
    initial
    begin
        void'($urandom(32'h1a0741c7));
        {reset, tx_wr, tx_go, tx_abort} = 4'hF;
        {tx_wr, tx_go, tx_abort} = 3'h0;
        {tx_wr_idx, tx_wr_data, tx_abort_label, rx_rd_idx} = '0;
        tx_msg = '0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        for (i = 1; i <= 11; i++)
        begin
            fill(i % (MTU - 1));
            send(4'(i), `AVSMF_MT_CMD, 6'(i), i % (MTU - 1), 1'b0);
        end
        $display("test single commands done");
        fill(20);
        send(4'hC, `AVSMF_MT_CMD, 6'h02, 7, 1'b0);
        send(4'hD, `AVSMF_MT_CMD, 6'h03, 20, 1'b0);
        send(4'hE, `AVSMF_MT_CMD, 6'h04, 20, 1'b1);
        $display("test fragments and abort done");
        peer.got.delete();
        fill(20);
        build(4'h1, `AVSMF_MT_ACC, 6'h01, 3);
        exp[1][7:6] = 2'h3;
        recv(4'h1, `AVSMF_MT_ACC, 6'h01, 3, 1'b1);
        build(4'hC, `AVSMF_MT_REJ, 6'h02, 20);
        recv(4'hC, `AVSMF_MT_REJ, 6'h02, 20, 1'b1);
        build(4'h2, `AVSMF_MT_RFD, 6'h05, 2);
        recv(4'h2, `AVSMF_MT_RFD, 6'h05, 2, 1'b0);
        build(4'h1, `AVSMF_MT_ACC, 6'h01, 2);
        recv(4'h1, `AVSMF_MT_ACC, 6'h01, 2, 1'b0);
        build(4'h3, `AVSMF_MT_ACC, 6'h03, 20);
        exp = exp[MTU:$];
        recv(4'h3, `AVSMF_MT_ACC, 6'h03, 20, 1'b0);
        build(4'h4, `AVSMF_MT_ACC, 6'h04, 20);
        exp[1][7:0] = exp[1][7:0] + 8'h01;
        recv(4'h4, `AVSMF_MT_ACC, 6'h04, 20, 1'b0);
        `chk(peer.got.size(), 0)
        $display("test receive checks done");
        build(4'h6, `AVSMF_MT_CMD, 6'h07, 4);
        recv(4'h6, `AVSMF_MT_CMD, 6'h07, 4, 1'b1);
        fill(9);
        send(4'(($urandom)), `AVSMF_MT_ACC, 6'h3F, 2, 1'b0);
        send(4'(($urandom)), `AVSMF_MT_REJ, 6'h00, 9, 1'b0);
        $display("test responses done");
        stop_test();
    end
endmodule : testbench
`default_nettype wire
